// *** serial_port_zero_pkg.sv ***
// Purpose: Shared constants and types for serial port zero
// Assumes: 25 MHz system clock, 4-bit nibble peripheral registers
// Notes: Offsets are peripheral addresses reached with PUT and GET
`default_nettype none
package serial_port_zero_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [6:0] ADDR_SHIFT_DATA = 7'h03;
  localparam logic [6:0] ADDR_IRQ_TIMING = 7'h38;
  localparam logic [6:0] ADDR_CLOCK_RATE = 7'h39;
  localparam logic [6:0] ADDR_MODE = 7'h3A;
  localparam logic [6:0] ADDR_STATUS = 7'h3B;
  localparam logic [6:0] ADDR_WAIT = 7'h3C;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int MODE_WIRING_BIT = 3;
  localparam int MODE_PROTOCOL_BIT = 2;
  localparam int MODE_MASTER_BIT = 1;
  localparam int MODE_DIR_BIT = 0;
  localparam int STAT_COUNT8_BIT = 3;
  localparam int STAT_COUNT9_BIT = 2;
  localparam int STAT_START_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int WAIT_ACK_BIT = 3;
  localparam int WAIT_RELEASE_BIT = 2;
  localparam int WAIT_COND_HI_BIT = 1;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam logic [1:0] CLOCK_RATE_RESET = 2'h0;
  localparam logic [3:0] WAIT_RESET = 4'h0;
  localparam logic [1:0] IRQ_TIMING_RESET = 2'h0;
  localparam logic [7:0] SHIFT_RESET = 8'h00;

  // ****************************************
  // Clock counter values
  // ****************************************
  localparam logic [3:0] COUNT_RESET = 4'h0;
  localparam logic [3:0] COUNT_RESTART = 4'h1;
  localparam logic [3:0] COUNT_SEVEN = 4'h7;
  localparam logic [3:0] COUNT_EIGHT = 4'h8;
  localparam logic [3:0] COUNT_NINE = 4'h9;

  // ****************************************
  // Shift clock timing
  // ****************************************
  localparam int SYS_CLK_HZ = 25_000_000;
  localparam int RATE_100K_HZ = 100_000;
  localparam int RATE_50K_HZ = 50_000;
  localparam int RATE_500K_HZ = 500_000;
  localparam int RATE_1M_HZ = 1_000_000;
  // Half periods round down so the rate never falls below the setting
  localparam logic [7:0] HALF_100K = 8'(SYS_CLK_HZ / (2 * RATE_100K_HZ));
  localparam logic [7:0] HALF_50K = 8'(SYS_CLK_HZ / (2 * RATE_50K_HZ));
  localparam logic [7:0] HALF_500K = 8'(SYS_CLK_HZ / (2 * RATE_500K_HZ));
  localparam logic [7:0] HALF_1M = 8'(SYS_CLK_HZ / (2 * RATE_1M_HZ));

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    RATE_100K = 2'b00,
    RATE_50K = 2'b01,
    RATE_500K = 2'b10,
    RATE_1M = 2'b11
  } clock_rate_t;

  typedef enum logic [1:0] {
    IRQ_AT_SEVEN = 2'b00,
    IRQ_AT_EIGHT = 2'b01,
    IRQ_SEVEN_AFTER_START = 2'b10,
    IRQ_AT_STOP = 2'b11
  } irq_timing_t;

  typedef struct packed {
    logic wiring_select;
    logic protocol_select;
    logic master_slave_select;
    logic direction_select;
  } mode_t;

  typedef struct packed {
    logic count_eight_flag;
    logic count_nine_flag;
    logic start_seen_flag;
    logic bus_busy_flag;
  } bus_status_t;

endpackage : serial_port_zero_pkg
`default_nettype wire

// *** sync2.sv ***
// Purpose: Two flip-flop level synchroniser
// Assumes: Each bit is an independent level or a slow toggle
// Notes: First stage feeds only the second stage
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule : sync2
`default_nettype wire

// *** serial_port_zero.sv ***
// Purpose: Serial port zero, two-wire bus or clocked serial I/O
// Assumes: Registers via peripheral address port; pins handled on link_clk
// Notes: Shift clock made on clk, pin logic on link_clk
//
// Functional notes
// - Mode bit 3 picks 2 or 3 wires, bit 2 picks bus or serial I/O.
// - Mode bit 1 picks internal or external clock, bit 0 picks direction.
// - Two wires use SDA and SCL; three wires use clock, out and in pins.
// - Two wires allow bus or serial I/O; three wires serial I/O only.
// - Rate field: 00 100 kHz, 01 50 kHz, 10 500 kHz, 11 1 MHz.
// - Rate register upper bits read zero; rate kept through clock stop and CE.
// - Generated shift clock reaches the pin only in master mode.
// - Wrap-around counter counts rising edges on the clock pin.
// - Counter samples the pin itself, internal or external clock alike.
// - Counter hidden from software; only status bits 3 and 2 show it.
// - In bus mode start and stop show in status bits 1 and 0.
// - Eight-bit shift register loaded and read only through the data buffer.
// - MSB goes out on falling edge, LSB captured on rising edge.
// - Only low eight buffer bits move; upper two nibbles ignored.
// - Wait bit 1 chooses where communication pauses, after clock 8 or 9; bit 0 is unused.
// - Setting wait bit 2 releases the wait and starts communication.
// - Wait bit 3 holds acknowledge, written for output, read after detection.
// - Interrupt mode bits 0 and 1 choose when the request is raised.
// - Counter starts at 0, 9 wraps to 1, clears on listed resets.
`default_nettype none
module serial_port_zero
  import serial_port_zero_pkg::*;
(
  // System clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Link clock for the pin logic
  input wire logic link_clk,
  // Reset events from the CPU core
  input wire logic clk_stop_req,
  input wire logic ce_rst_req,
  // Peripheral register port
  input wire logic [6:0] per_addr,
  input wire logic per_wr,
  input wire logic per_rd,
  input wire logic [15:0] per_wdata,
  output logic [15:0] per_rdata,
  // Interrupt request toward the CPU flag
  output logic irq_req,
  // Two-wire pins
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  // Three-wire pins
  input wire logic shift_clock_pin_i,
  output logic shift_clock_pin_o,
  output logic shift_clock_pin_oe,
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe,
  input wire logic serial_in_pin_i
);

  // ****************************************
  // System clock domain registers
  // ****************************************
  mode_t mode_r;
  logic [1:0] rate_r;
  logic [3:0] wait_r;
  logic [1:0] irq_mode_r;
  logic [7:0] load_data_r;
  logic load_pend_r;
  logic load_tgl_r;
  logic clr_tgl_r;
  logic [7:0] shift_rd_r;
  logic snap_pend_r;
  logic [3:0] evt_seen_r;
  logic sck_gen_r;
  logic [7:0] half_cnt_r;
  logic [7:0] half_len;
  logic gen_run;
  logic gen_idle_level;

  // From the link domain
  logic [3:0] evt_tgl_s;
  logic [7:0] snap_s;
  logic ack_s;
  bus_status_t status_s;
  logic [3:0] evt_edge;

  assign evt_edge = evt_tgl_s ^ evt_seen_r;

  // Register writes, masked to each register width
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mode_r <= mode_t'(MODE_RESET);
      rate_r <= CLOCK_RATE_RESET;
      irq_mode_r <= IRQ_TIMING_RESET;
    end else if (per_wr) begin
      if (per_addr == ADDR_MODE) begin
        mode_r <= mode_t'(per_wdata[3:0]);
      end else if (per_addr == ADDR_CLOCK_RATE) begin
        rate_r <= per_wdata[1:0];
      end else if (per_addr == ADDR_IRQ_TIMING) begin
        irq_mode_r <= per_wdata[1:0];
      end
    end
  end

  // Wait register: write beats the hardware wait entry in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wait_r <= WAIT_RESET;
    end else if (per_wr && per_addr == ADDR_WAIT) begin
      wait_r <= per_wdata[3:0];
    end else begin
      if (evt_edge[0]) begin
        wait_r[WAIT_RELEASE_BIT] <= 1'b0;
      end
      if (evt_edge[2]) begin
        wait_r[WAIT_ACK_BIT] <= ack_s;
      end
    end
  end

  // Shift data load handshake; toggle trails the data by one cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      load_data_r <= SHIFT_RESET;
      load_pend_r <= 1'b0;
      load_tgl_r <= 1'b0;
    end else begin
      load_pend_r <= 1'b0;
      if (per_wr && per_addr == ADDR_SHIFT_DATA) begin
        load_data_r <= per_wdata[7:0];
        load_pend_r <= 1'b1;
      end
      if (load_pend_r) begin
        load_tgl_r <= ~load_tgl_r;
      end
    end
  end

  // Clock stop and CE reset clear the counter only, rate and modes hold
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      clr_tgl_r <= 1'b0;
    end else if (clk_stop_req || ce_rst_req) begin
      clr_tgl_r <= ~clr_tgl_r;
    end
  end

  // Events from the link; snapshot captured a cycle after its toggle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      evt_seen_r <= 4'h0;
      snap_pend_r <= 1'b0;
      shift_rd_r <= SHIFT_RESET;
      irq_req <= 1'b0;
    end else begin
      evt_seen_r <= evt_tgl_s;
      snap_pend_r <= evt_edge[3];
      if (snap_pend_r) begin
        shift_rd_r <= snap_s;
      end
      irq_req <= evt_edge[1];
    end
  end

  // Register reads, answered on the following edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      per_rdata <= 16'h0000;
    end else if (per_rd) begin
      if (per_addr == ADDR_SHIFT_DATA) begin
        per_rdata <= {8'h00, shift_rd_r};
      end else if (per_addr == ADDR_CLOCK_RATE) begin
        per_rdata <= {14'h0000, rate_r};
      end else if (per_addr == ADDR_IRQ_TIMING) begin
        per_rdata <= {14'h0000, irq_mode_r};
      end else if (per_addr == ADDR_MODE) begin
        per_rdata <= {12'h000, mode_r};
      end else if (per_addr == ADDR_STATUS) begin
        per_rdata <= {12'h000, status_s};
      end else if (per_addr == ADDR_WAIT) begin
        per_rdata <= {12'h000, wait_r};
      end else begin
        per_rdata <= 16'h0000;
      end
    end
  end

  // ****************************************
  // Internal shift clock generator
  // ****************************************
  always_comb begin
    case (clock_rate_t'(rate_r))
      RATE_100K: half_len = HALF_100K;
      RATE_50K: half_len = HALF_50K;
      RATE_500K: half_len = HALF_500K;
      default: half_len = HALF_1M;
    endcase
  end

  // In bus mode the clock rests low during a wait; serial I/O rests high
  assign gen_idle_level = ~(mode_r.protocol_select & ~mode_r.wiring_select);
  assign gen_run = mode_r.master_slave_select & wait_r[WAIT_RELEASE_BIT];

  // A stopped clock finishes its half period before resting
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sck_gen_r <= 1'b1;
      half_cnt_r <= 8'h00;
    end else if (!gen_run && sck_gen_r == gen_idle_level) begin
      half_cnt_r <= 8'h00;
    end else if (half_cnt_r >= half_len - 8'h01) begin
      half_cnt_r <= 8'h00;
      sck_gen_r <= ~sck_gen_r;
    end else begin
      half_cnt_r <= half_cnt_r + 8'h01;
    end
  end

  // ****************************************
  // Domain crossings
  // ****************************************
  logic link_rst_b;
  logic [3:0] pins_s;
  logic [19:0] ctl_s;
  logic [16:0] back_l;
  logic [16:0] back_s;

  sync2 #(.W(1)) u_link_rst (
    .clk(link_clk),
    .rst_b(1'b1),
    .d(rst_b),
    .q(link_rst_b)
  );

  // Left unreset so the edge detectors start from the real pin levels
  sync2 #(.W(4)) u_pins (
    .clk(link_clk),
    .rst_b(1'b1),
    .d({scl_i, sda_i, shift_clock_pin_i, serial_in_pin_i}),
    .q(pins_s)
  );

  sync2 #(.W(20)) u_ctl (
    .clk(link_clk),
    .rst_b(link_rst_b),
    .d({mode_r, sck_gen_r, wait_r[WAIT_ACK_BIT], irq_mode_r, wait_r[1:0], load_tgl_r,
        clr_tgl_r, load_data_r}),
    .q(ctl_s)
  );

  sync2 #(.W(17)) u_back (
    .clk(clk),
    .rst_b(rst_b),
    .d(back_l),
    .q(back_s)
  );

  assign {evt_tgl_s, snap_s, ack_s, status_s} = back_s;

  // ****************************************
  // Link domain
  // ****************************************
  mode_t mode_l;
  logic gen_l;
  logic ack_out_l;
  logic [1:0] irq_mode_l;
  logic [1:0] wait_cond_l;
  logic load_tgl_l;
  logic clr_tgl_l;
  logic [7:0] load_data_l;
  assign {mode_l, gen_l, ack_out_l, irq_mode_l, wait_cond_l, load_tgl_l, clr_tgl_l,
          load_data_l} = ctl_s;

  logic cpin;
  logic dpin;
  logic cpin_d_r;
  logic dpin_d_r;
  logic bus_mode;
  logic bus_mode_d_r;
  logic rise;
  logic fall;
  logic start_det;
  logic stop_det;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [7:0] shift_r;
  logic load_seen_r;
  logic clr_seen_r;
  logic dout_r;
  logic start_seen_r;
  logic busy_r;
  logic cnt8_r;
  logic cnt9_r;
  logic [7:0] snap_r;
  logic ack_samp_r;
  logic [2:0] evt_tgl_r;
  logic upd_tgl_r;
  logic wait_hit;
  logic irq_hit;
  logic [3:0] wait_count;

  assign cpin = mode_l.wiring_select ? pins_s[1] : pins_s[3];
  assign dpin = mode_l.wiring_select ? pins_s[0] : pins_s[2];
  assign bus_mode = mode_l.protocol_select & ~mode_l.wiring_select;
  assign rise = cpin & ~cpin_d_r;
  assign fall = ~cpin & cpin_d_r;
  assign start_det = bus_mode & cpin & cpin_d_r & dpin_d_r & ~dpin;
  assign stop_det = bus_mode & cpin & cpin_d_r & ~dpin_d_r & dpin;
  assign cnt_nxt = (cnt_r == COUNT_NINE) ? COUNT_RESTART : cnt_r + 4'h1;
  assign wait_count = wait_cond_l[WAIT_COND_HI_BIT] ? COUNT_NINE : COUNT_EIGHT;
  assign wait_hit = rise & (cnt_nxt == wait_count);

  always_comb begin
    irq_hit = 1'b0;
    case (irq_timing_t'(irq_mode_l))
      IRQ_AT_SEVEN: irq_hit = rise & (cnt_nxt == COUNT_SEVEN);
      IRQ_AT_EIGHT: irq_hit = rise & (cnt_nxt == COUNT_EIGHT);
      IRQ_SEVEN_AFTER_START: irq_hit = bus_mode & start_seen_r & rise & (cnt_nxt == COUNT_SEVEN);
      default: irq_hit = stop_det;
    endcase
  end

  always_ff @(posedge link_clk) begin
    if (!link_rst_b) begin
      cpin_d_r <= 1'b1;
      dpin_d_r <= 1'b1;
      bus_mode_d_r <= 1'b0;
    end else begin
      cpin_d_r <= cpin;
      dpin_d_r <= dpin;
      bus_mode_d_r <= bus_mode;
    end
  end

  // Clock counter and its derived flags
  always_ff @(posedge link_clk) begin
    if (!link_rst_b) begin
      cnt_r <= COUNT_RESET;
      clr_seen_r <= 1'b0;
      cnt8_r <= 1'b0;
      cnt9_r <= 1'b0;
    end else begin
      clr_seen_r <= clr_tgl_l;
      if (start_det || (bus_mode_d_r && !bus_mode) || clr_tgl_l != clr_seen_r) begin
        cnt_r <= COUNT_RESET;
      end else if (rise) begin
        cnt_r <= cnt_nxt;
      end
      cnt8_r <= (cnt_r == COUNT_EIGHT);
      cnt9_r <= (cnt_r == COUNT_NINE);
    end
  end

  // Start and stop detection
  always_ff @(posedge link_clk) begin
    if (!link_rst_b) begin
      start_seen_r <= 1'b0;
      busy_r <= 1'b0;
    end else if (!bus_mode || stop_det) begin
      start_seen_r <= 1'b0;
      busy_r <= 1'b0;
    end else if (start_det) begin
      start_seen_r <= 1'b1;
      busy_r <= 1'b1;
    end
  end

  // Shift register, each update published back as a snapshot
  always_ff @(posedge link_clk) begin
    if (!link_rst_b) begin
      shift_r <= SHIFT_RESET;
      load_seen_r <= 1'b0;
      snap_r <= SHIFT_RESET;
      upd_tgl_r <= 1'b0;
    end else begin
      load_seen_r <= load_tgl_l;
      if (load_tgl_l != load_seen_r) begin
        shift_r <= load_data_l;
        snap_r <= load_data_l;
        upd_tgl_r <= ~upd_tgl_r;
      end else if (rise) begin
        shift_r <= {shift_r[6:0], dpin};
        snap_r <= {shift_r[6:0], dpin};
        upd_tgl_r <= ~upd_tgl_r;
      end
    end
  end

  // Data out on the falling edge; ninth clock slot carries acknowledge
  always_ff @(posedge link_clk) begin
    if (!link_rst_b) begin
      dout_r <= 1'b1;
    end else if (fall) begin
      if (bus_mode && cnt_r == COUNT_EIGHT) begin
        dout_r <= mode_l.direction_select | ack_out_l;
      end else begin
        dout_r <= ~mode_l.direction_select | shift_r[7];
      end
    end
  end

  // Events toward the system clock
  always_ff @(posedge link_clk) begin
    if (!link_rst_b) begin
      evt_tgl_r[2:0] <= 3'h0;
      ack_samp_r <= 1'b0;
    end else begin
      if (wait_hit) begin
        evt_tgl_r[0] <= ~evt_tgl_r[0];
      end
      if (irq_hit) begin
        evt_tgl_r[1] <= ~evt_tgl_r[1];
      end
      if (bus_mode && mode_l.direction_select && rise && cnt_nxt == COUNT_NINE) begin
        ack_samp_r <= dpin;
        evt_tgl_r[2] <= ~evt_tgl_r[2];
      end
    end
  end

  assign back_l = {upd_tgl_r, evt_tgl_r, snap_r, ack_samp_r, cnt8_r, cnt9_r, start_seen_r, busy_r};

  // Pin drivers; open-drain lines only ever pull low
  always_ff @(posedge link_clk) begin
    if (!link_rst_b) begin
      sda_o <= 1'b0;
      sda_oe <= 1'b0;
      scl_o <= 1'b0;
      scl_oe <= 1'b0;
      shift_clock_pin_o <= 1'b1;
      shift_clock_pin_oe <= 1'b0;
      serial_out_pin_o <= 1'b1;
      serial_out_pin_oe <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      sda_oe <= ~mode_l.wiring_select & ~dout_r;
      scl_o <= 1'b0;
      scl_oe <= ~mode_l.wiring_select & mode_l.master_slave_select & ~gen_l;
      shift_clock_pin_o <= gen_l;
      shift_clock_pin_oe <= mode_l.wiring_select & mode_l.master_slave_select;
      serial_out_pin_o <= dout_r;
      serial_out_pin_oe <= mode_l.wiring_select & mode_l.direction_select;
    end
  end

endmodule : serial_port_zero
`default_nettype wire

// *** serial_port_zero_tb_placeholder_none.sv ***
`default_nettype none
`default_nettype wire

// *** serial_port_zero_props.sv ***
// Purpose: Port checks for serial port zero
// Assumes: Top module ports only
// Notes: Pin outputs are sampled on clk as well
`default_nettype none
module serial_port_zero_props
  import serial_port_zero_pkg::*;
(
  // Clock, reset and registers
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [6:0] per_addr,
  input wire logic per_wr,
  input wire logic per_rd,
  input wire logic [15:0] per_wdata,
  input wire logic [15:0] per_rdata,
  input wire logic irq_req,
  // Pins
  input wire logic sda_o,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic shift_clock_pin_o,
  input wire logic shift_clock_pin_oe,
  input wire logic serial_out_pin_o
);
  logic [3:0] mode_r;
  logic [3:0] age_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Age gives the pin domain time to follow a mode write
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mode_r <= MODE_RESET;
      age_r <= 4'h0;
    end else if (per_wr && per_addr == ADDR_MODE) begin
      mode_r <= per_wdata[3:0];
      age_r <= 4'h0;
    end else if (age_r != 4'hF) begin
      age_r <= age_r + 4'h1;
    end
  end
  // ****
  // Checks
  // ****
  sequence s_rd(logic [6:0] a);
    per_rd && per_addr == a;
  endsequence
  sequence s_go;
    per_wr && per_addr == ADDR_WAIT && per_wdata[WAIT_RELEASE_BIT] && mode_r[3:1] == 3'h5;
  endsequence
  property p_rst_quiet; $rose(rst_b) |-> per_rdata == 16'h0000 && !irq_req; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("Outputs not clear");
  property p_stat_hi; s_rd(ADDR_STATUS) |=> per_rdata[15:4] == 12'h000; endproperty
  a_stat_hi: assert property (p_stat_hi) else $error("Status upper bits set");
  property p_rate_hi; s_rd(ADDR_CLOCK_RATE) |=> per_rdata[15:2] == 14'h0000; endproperty
  a_rate_hi: assert property (p_rate_hi) else $error("Rate upper bits set");
  property p_shift_hi; s_rd(ADDR_SHIFT_DATA) |=> per_rdata[15:8] == 8'h00; endproperty
  a_shift_hi: assert property (p_shift_hi) else $error("Shift data too wide");
  property p_irq_pulse; irq_req |=> !irq_req; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("Request too long");
  property p_slave_quiet;
    age_r > 4'h7 && !mode_r[MODE_MASTER_BIT] |-> !shift_clock_pin_oe && !scl_oe;
  endproperty
  a_slave_quiet: assert property (p_slave_quiet) else $error("Clock driven as slave");
  property p_od_low; !sda_o && !scl_o; endproperty
  a_od_low: assert property (p_od_low) else $error("Open drain drives high");
  property p_data_hold; $rose(shift_clock_pin_o) |-> $stable(serial_out_pin_o)[*3]; endproperty
  a_data_hold: assert property (p_data_hold) else $error("Data moved at rise");
  property p_go; s_go |-> ##[1:600] $fell(shift_clock_pin_o); endproperty
  a_go: assert property (p_go) else $error("No clock after release");
endmodule : serial_port_zero_props
bind serial_port_zero serial_port_zero_props u_props (.clk, .rst_b, .per_addr, .per_wr,
  .per_rd, .per_wdata, .per_rdata, .irq_req, .sda_o, .scl_o, .scl_oe, .shift_clock_pin_o,
  .shift_clock_pin_oe, .serial_out_pin_o);
`default_nettype wire

// *** serial_peer.sv ***
// Purpose: Far-side peer on the serial port zero pins
// Assumes: Pull-ups on SDA, SCL and the shift clock pin
// Notes: Serial input line is inverted after each byte
`default_nettype none
module serial_peer (
  // From the device
  input wire logic sda_oe,
  input wire logic scl_oe,
  input wire logic shift_clock_pin_o,
  input wire logic shift_clock_pin_oe,
  input wire logic serial_out_pin_o,
  // To the device
  output logic sda_i,
  output logic scl_i,
  output logic shift_clock_pin_i,
  output logic serial_in_pin_i
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sda_low_r = 1'b0, scl_low_r = 1'b0, ext_on_r = 1'b0, ext_r = 1'b1, si_r = 1'b1;
  logic [7:0] tx_r = 8'h00, rx_r = 8'h00;
  logic [2:0] cnt_r = 3'h0;
  // Wired-AND lines
  assign sda_i = !(sda_oe || sda_low_r);
  assign scl_i = !(scl_oe || scl_low_r);
  assign shift_clock_pin_i = shift_clock_pin_oe ? shift_clock_pin_o : (!ext_on_r || ext_r);
  assign serial_in_pin_i = si_r;
  always @(negedge shift_clock_pin_i) begin
    si_r <= tx_r[7];
    tx_r <= {tx_r[6:0], 1'b0};
  end
  // Inverting after the last bit stops a stale level passing as data
  always @(posedge shift_clock_pin_i) begin
    rx_r <= {rx_r[6:0], serial_out_pin_o};
    cnt_r <= cnt_r + 3'h1;
    if (cnt_r == 3'h7) begin
      si_r <= #60 !si_r;
    end
  end
  task automatic load(input logic [7:0] b);
    tx_r = b;
  endtask : load
  task automatic ext_clock(input int n, input int h);
    ext_on_r = 1'b1;
    repeat (n) begin
      ext_r = 1'b0;
      #h;
      ext_r = 1'b1;
      #h;
    end
    ext_on_r = 1'b0;
  endtask : ext_clock
  task automatic bus_clock(input int n);
    repeat (n) begin
      scl_low_r = 1'b1;
      #300;
      scl_low_r = 1'b0;
      #300;
    end
  endtask : bus_clock
  task automatic bus_start();
    scl_low_r = 1'b1;
    #300;
    sda_low_r = 1'b0;
    #300;
    scl_low_r = 1'b0;
    #300;
    sda_low_r = 1'b1;
    #300;
  endtask : bus_start
  task automatic bus_stop();
    sda_low_r = 1'b1;
    #300;
    sda_low_r = 1'b0;
    #300;
  endtask : bus_stop
endmodule : serial_peer
`default_nettype wire

// *** testbench.sv ***
// Purpose: Self-checking bench for serial port zero
// Assumes: Peer model on the pins, link clock 6 ns
// Notes: Inputs change on the falling clk edge
`default_nettype none
module testbench import serial_port_zero_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [6:0] a;
    logic [15:0] d;
    logic [15:0] e;
  } row_t;
  logic clk, link_clk, rst_b, clk_stop_req, ce_rst_req, per_wr, per_rd, irq_req, seen;
  logic sda_i, sda_o, sda_oe, scl_i, scl_o, scl_oe, shift_clock_pin_i, shift_clock_pin_o;
  logic shift_clock_pin_oe, serial_out_pin_o, serial_out_pin_oe, serial_in_pin_i;
  logic [6:0] per_addr;
  logic [15:0] per_wdata, per_rdata, q;
  int err_total = 0;
  int tests_run = 0;
  int halves [4] = '{HALF_100K, HALF_50K, HALF_500K, HALF_1M};
  row_t rows [7] = '{
    '{ADDR_CLOCK_RATE, 16'hFFFF, 16'h0003},
    '{ADDR_MODE, 16'h000A, 16'h000A},
    '{ADDR_WAIT, 16'h000B, 16'h000B},
    '{ADDR_IRQ_TIMING, 16'hFFF3, 16'h0003},
    '{ADDR_SHIFT_DATA, 16'hABCD, 16'h00CD},
    '{ADDR_STATUS, 16'h000F, 16'h0000},
    '{7'h40, 16'h1234, 16'h0000}};
  serial_port_zero dut (.clk, .rst_b, .link_clk, .clk_stop_req, .ce_rst_req, .per_addr,
    .per_wr, .per_rd, .per_wdata, .per_rdata, .irq_req, .sda_i, .sda_o, .sda_oe, .scl_i,
    .scl_o, .scl_oe, .shift_clock_pin_i, .shift_clock_pin_o, .shift_clock_pin_oe,
    .serial_out_pin_o, .serial_out_pin_oe, .serial_in_pin_i);
  serial_peer peer (.sda_oe, .scl_oe, .shift_clock_pin_o, .shift_clock_pin_oe,
    .serial_out_pin_o, .sda_i, .scl_i, .shift_clock_pin_i, .serial_in_pin_i);
  initial begin
    clk = 1'b0;
    forever #20 clk = !clk;
  end
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #3 link_clk = !link_clk;
  end
  task automatic chk(input logic [15:0] sv, input logic [15:0] ev);
    tests_run++;
    if (sv !== ev) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, sv, ev);
    end
  endtask : chk
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(negedge clk);
    per_addr = a;
    per_wdata = d;
    per_wr = 1'b1;
    @(negedge clk);
    per_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [15:0] v);
    @(negedge clk);
    per_addr = a;
    per_rd = 1'b1;
    @(negedge clk);
    per_rd = 1'b0;
    v = per_rdata;
  endtask : rd
  task automatic pulse(input logic stop);
    @(negedge clk);
    clk_stop_req = stop;
    ce_rst_req = !stop;
    @(negedge clk);
    clk_stop_req = 1'b0;
    ce_rst_req = 1'b0;
    // Let the counter clear reach the status flags
    repeat (4) @(negedge clk);
  endtask : pulse
  task automatic wait_irq();
    seen = 1'b0;
    for (int n = 0; n < 6000 && !seen; n++) begin
      @(negedge clk);
      seen = (irq_req === 1'b1);
    end
  endtask : wait_irq
  task automatic wait_pin(input logic lv, output int n);
    n = 0;
    while (shift_clock_pin_o !== lv && n < 1000) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_pin
  // Three-wire master byte; counter cleared first so the byte is eight clocks
  task automatic xfer(input int r, input logic [7:0] tx, input logic [7:0] rx);
    int n;
    pulse(1'b1);
    wr(ADDR_CLOCK_RATE, 16'(r));
    wr(ADDR_MODE, 16'h000B);
    wr(ADDR_IRQ_TIMING, 16'h0001);
    wr(ADDR_SHIFT_DATA, {8'h5A, tx});
    peer.load(rx);
    wr(ADDR_WAIT, 16'h0004);
    wait_pin(1'b0, n);
    wait_pin(1'b1, n);
    chk(16'(n >= halves[r] - 1 && n <= halves[r] + 1), 16'h0001);
    wait_irq();
    chk({15'h0, seen}, 16'h0001);
    n = 0;
    do begin
      rd(ADDR_WAIT, q);
      n++;
    end while (q[2] !== 1'b0 && n < 100);
    chk(q, 16'h0000);
    chk({8'h0, peer.rx_r}, {8'h0, tx});
    rd(ADDR_SHIFT_DATA, q);
    chk(q, {8'h0, rx});
    rd(ADDR_STATUS, q);
    chk(q, 16'h0008);
  endtask : xfer
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up
  initial begin
    #3_000_000;
    err_total++;
    wrap_up();
  end
  initial begin
    {rst_b, clk_stop_req, ce_rst_req, per_wr, per_rd} = 5'h00;
    per_addr = 7'h00;
    per_wdata = 16'h0000;
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      repeat (8) @(negedge clk);
      rd(rows[i].a, q);
      chk(q, rows[i].e);
    end
    rst_b = 1'b0;
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    foreach (rows[i]) begin
      rd(rows[i].a, q);
      chk(q, 16'h0000);
    end
    for (int r = 0; r < 4; r++) begin
      xfer(r, 8'hA5 ^ 8'(r), 8'h3C + 8'(r));
    end
    pulse(1'b0);
    rd(ADDR_STATUS, q);
    chk(q, 16'h0000);
    wr(ADDR_MODE, 16'h0008);
    wr(ADDR_IRQ_TIMING, 16'h0000);
    peer.load(8'hC3);
    wr(ADDR_WAIT, 16'h0004);
    fork
      peer.ext_clock(8, 200);
      wait_irq();
    join
    chk({15'h0, seen}, 16'h0001);
    rd(ADDR_SHIFT_DATA, q);
    chk(q, 16'h00C3);
    // Mode values never pair three wires with bus protocol
    wr(ADDR_MODE, 16'h0004);
    wr(ADDR_WAIT, 16'h000E);
    wr(ADDR_IRQ_TIMING, 16'h0002);
    peer.bus_start();
    fork
      peer.bus_clock(9);
      wait_irq();
    join
    chk({15'h0, seen}, 16'h0001);
    rd(ADDR_STATUS, q);
    chk({13'h0, q[3:1]}, 16'h0003);
    pulse(1'b1);
    wr(ADDR_WAIT, 16'h000E);
    peer.bus_clock(8);
    rd(ADDR_STATUS, q);
    chk({14'h0, q[3:2]}, 16'h0002);
    peer.bus_start();
    rd(ADDR_STATUS, q);
    chk({14'h0, q[3:2]}, 16'h0000);
    wr(ADDR_IRQ_TIMING, 16'h0003);
    fork
      peer.bus_stop();
      wait_irq();
    join
    chk({15'h0, seen}, 16'h0001);
    rd(ADDR_STATUS, q);
    chk({15'h0, q[0]}, 16'h0000);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
